// file: verif/test_afrmc_top.sv
// self-checking bench for the filter rate and mode control block
`timescale 1ns/1ns

module test_afrmc_top;
  logic core_clk;
  logic reset;
  afrmc_pkg::afrmc_cfg_type cfg_in;
  logic cfg_load;
  logic mclk_pin;
  afrmc_pkg::afrmc_sample_type sample_in;
  logic conv_strobe_reg;
  logic data_valid_reg;
  logic [31:0] read_word_reg;
  logic [5:0] read_bits_reg;
  logic [22:0] divide_total_reg;
  logic [2:0] filter_order_reg;
  logic zero_latency_reg;
  afrmc_pkg::afrmc_notch_type notch_reg;
  logic cfg_error_reg;
  int mismatches;
  int num_checks;
  int cyc;

  afrmc_top uut (
    .core_clk(core_clk), .reset(reset), .cfg_in(cfg_in), .cfg_load(cfg_load),
    .mclk_pin(mclk_pin), .sample_in(sample_in), .conv_strobe_reg(conv_strobe_reg),
    .data_valid_reg(data_valid_reg), .read_word_reg(read_word_reg),
    .read_bits_reg(read_bits_reg), .divide_total_reg(divide_total_reg),
    .filter_order_reg(filter_order_reg), .zero_latency_reg(zero_latency_reg),
    .notch_reg(notch_reg), .cfg_error_reg(cfg_error_reg)
  );

  // ----------------------------------------
  // clock and master clock
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // master clock: each level held 3 cycles, one tick per 6 cycles
  initial begin
    mclk_pin = 1'b0;
    forever begin
      repeat (3) @(posedge core_clk);
      mclk_pin <= ~mclk_pin;
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(logic [31:0] got, logic [31:0] exp, string what);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  function automatic afrmc_pkg::afrmc_cfg_type mk(logic par, logic app, logic res,
      logic settle, logic rej, logic ord, logic chop, logic cont, logic multi,
      logic [9:0] code);
    return {par, app, res, settle, rej, ord, chop, cont, multi, code};
  endfunction

  task automatic load(afrmc_pkg::afrmc_cfg_type c);
    @(posedge core_clk);
    cfg_in <= c;
    cfg_load <= 1'b1;
    @(posedge core_clk);
    cfg_load <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  task automatic decoded(logic [22:0] tot, logic [2:0] ord, logic zl, logic [3:0] n,
      logic err);
    check(32'(divide_total_reg), 32'(tot), "divide total");
    check(32'(filter_order_reg), 32'(ord), "filter order");
    check(32'(zero_latency_reg), 32'(zl), "zero latency");
    check(32'(notch_reg), 32'(n), "notch summary");
    check(32'(cfg_error_reg), 32'(err), "config error");
  endtask

  task automatic wait_strobe();
    cyc = 0;
    do begin
      @(posedge core_clk);
      #1;
      cyc++;
    end while (conv_strobe_reg !== 1'b1 && cyc < 40000);
    check(32'(conv_strobe_reg), 32'h1, "conversion strobe");
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_reset_state();
    repeat (2) @(posedge core_clk);
    #1;
    decoded(23'h018000, 3'h4, 1'b0, 4'hC, 1'b0);
    check(32'(read_bits_reg), 32'h18, "reset bit count");
    $display("test reset_state done");
  endtask

  task automatic test_decode();
    load(mk(0, 0, 0, 0, 1, 0, 0, 1, 0, 10'h060));
    decoded(23'h018000, 3'h4, 1'b0, 4'hE, 1'b0);
    load(mk(0, 0, 0, 0, 1, 0, 0, 1, 0, 10'h061));
    decoded(23'h018400, 3'h4, 1'b0, 4'h8, 1'b0);
    load(mk(0, 0, 0, 0, 0, 0, 1, 1, 0, 10'h00A));
    decoded(23'h00A000, 3'h4, 1'b0, 4'h1, 1'b0);
    load(mk(0, 0, 0, 0, 0, 1, 1, 1, 0, 10'h3FF));
    decoded(23'h2FF400, 3'h3, 1'b0, 4'h1, 1'b0);
    load(mk(0, 0, 0, 1, 0, 0, 0, 1, 0, 10'h005));
    decoded(23'h005000, 3'h4, 1'b1, 4'h8, 1'b0);
    load(mk(0, 0, 0, 1, 0, 0, 0, 1, 1, 10'h005));
    decoded(23'h001400, 3'h4, 1'b0, 4'h0, 1'b0);
    load(mk(0, 0, 0, 1, 0, 0, 0, 0, 0, 10'h005));
    decoded(23'h001400, 3'h4, 1'b0, 4'h8, 1'b0);
    load(mk(0, 0, 0, 0, 0, 0, 0, 1, 0, 10'h000));
    decoded(23'h000400, 3'h4, 1'b0, 4'h8, 1'b1);
    load(mk(0, 0, 1, 0, 0, 0, 0, 1, 0, 10'h060));
    decoded(23'h018000, 3'h4, 1'b0, 4'hC, 1'b1);
    $display("test decode done");
  endtask

  task automatic test_chop_append();
    logic [23:0] d;
    d = 24'hA5C3F1;
    @(posedge core_clk);
    sample_in <= {d, 3'h5};
    load(mk(1, 1, 0, 0, 0, 1, 1, 1, 0, 10'h001));
    wait_strobe();
    check(32'(data_valid_reg), 32'h1, "chop first valid");
    check(read_word_reg, {d, 3'h0, ^d, 1'b0, 3'h5}, "word with status");
    check(32'(read_bits_reg), 32'h20, "bit count append");
    wait_strobe();
    check(32'(cyc), 32'd18432, "chop period");
    $display("test chop_append done");
  endtask

  task automatic test_plain_settle();
    logic [31:0] prev;
    logic [23:0] d;
    prev = read_word_reg;
    d = 24'h3C0E77;
    @(posedge core_clk);
    sample_in <= {d, 3'h2};
    load(mk(0, 0, 0, 0, 0, 1, 0, 1, 0, 10'h001));
    for (int i = 0; i < 2; i++) begin
      wait_strobe();
      check(32'(data_valid_reg), 32'h0, "unsettled flag");
      check(read_word_reg, prev, "word held");
    end
    wait_strobe();
    check(32'(cyc), 32'd6144, "plain period");
    check(32'(data_valid_reg), 32'h1, "settled flag");
    check(read_word_reg, {8'h00, d}, "word without status");
    check(32'(read_bits_reg), 32'h18, "bit count plain");
    $display("test plain_settle done");
  endtask

  task automatic test_zero_latency();
    logic [23:0] d;
    d = 24'h5A0C81;
    @(posedge core_clk);
    sample_in <= {d, 3'h3};
    load(mk(0, 1, 1, 1, 0, 0, 0, 1, 0, 10'h001));
    wait_strobe();
    check(32'(data_valid_reg), 32'h1, "zero latency first valid");
    check(read_word_reg, {d, 8'h43}, "status with config error");
    check(32'(zero_latency_reg), 32'h1, "zero latency flag");
    $display("test zero_latency done");
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    mismatches = 0;
    num_checks = 0;
    reset = 1'b1;
    cfg_in = '0;
    cfg_load = 1'b0;
    sample_in = '0;
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    test_reset_state();
    test_decode();
    test_chop_append();
    test_plain_settle();
    test_zero_latency();
    final_report();
  end

  initial begin
    #720000;
    mismatches++;
    final_report();
  end
endmodule

// file: verilog/afrmc_defines.svh
// constants for the filter rate and mode control block
// Overview of operation
// - A set parity enable puts the data parity bit in the status byte appended to each data word.
// - With status append set, each data read carries the status byte after the data.
// - A set single-cycle settle bit makes every conversion settled, giving zero latency.
// - Single-cycle settle is ignored with several channels enabled or in single conversion.
// - With the sixty-hertz bit set and the first notch at 50 Hz, a 60 Hz notch is added.
// - The 10-bit rate divider code, 1 to 1023, sets cutoff, first notch and output rate.
// - Without chopping or zero latency in continuous mode the output rate is master clock / 1024 / code.
// - Without chopping the first notch equals the output rate on a single channel.
// - With chopping the rate is master clock / 1024 / (filter order times code).
// - With chopping extra notches appear at odd multiples of a rate-derived frequency.
// - Order select clear picks fourth order, set picks third order, the N of the chop rate.
`ifndef AFRMC_DEFINES_SVH
`define AFRMC_DEFINES_SVH

// ----------------------------------------
// widths
// ----------------------------------------
`define AFRMC_FS_W 10
`define AFRMC_DATA_W 24
`define AFRMC_STAT_W 8
`define AFRMC_WORD_W 32

// ----------------------------------------
// rate figures
// ----------------------------------------
`define AFRMC_PRE_DIV 1024
`define AFRMC_PRE_MAX 10'h3FF
`define AFRMC_MCLK_HZ 4920000
`define AFRMC_MAINS_A_HZ 50
`define AFRMC_FS_50HZ (`AFRMC_MCLK_HZ / `AFRMC_PRE_DIV / `AFRMC_MAINS_A_HZ)
`define AFRMC_ORDER_SINC4 3'h4
`define AFRMC_ORDER_FILTER_ORDER_SELECT 3'h3

// ----------------------------------------
// reset values and status fields
// ----------------------------------------
`define AFRMC_FS_RESET 10'h060
`define AFRMC_BITS_PLAIN 6'h18
`define AFRMC_BITS_APPEND 6'h20
`define AFRMC_ST_RDY_N 7
`define AFRMC_ST_ERR 6
`define AFRMC_ST_PAR 4

`endif

// file: verilog/afrmc_pkg.sv
// shared types of the filter rate and mode control block
package afrmc_pkg;

  // mode configuration as written by host software
  typedef struct packed {
    logic parity_check_enable;
    logic status_append_enable;
    logic reserved_zero_bit;
    logic single_cycle_settle;
    logic sixty_hertz_notch_enable;
    logic filter_order_select;
    logic chop_enable;
    logic continuous_mode;
    logic multi_channel;
    logic [9:0] rate_divider_code;
  } afrmc_cfg_type;

  // one converted sample from the modulator side
  typedef struct packed {
    logic [23:0] data;
    logic [2:0] chan;
  } afrmc_sample_type;

  // filter response summary
  typedef struct packed {
    logic first_notch_at_rate;
    logic first_notch_50hz;
    logic notch_60hz_added;
    logic chop_odd_notches;
  } afrmc_notch_type;

endpackage

// file: verilog/afrmc_rate_div.sv
// divider from master clock ticks to conversion pulses
`timescale 1ns/1ns
`include "afrmc_defines.svh"

module afrmc_rate_div (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // control
  input wire logic restart,
  input wire logic mclk_tick,
  input wire logic [9:0] fs_code,
  input wire logic [2:0] mult,
  // result
  output logic conv_pulse
);

  logic [9:0] pre_reg;
  logic [9:0] fs_cnt_reg;
  logic [2:0] mult_cnt_reg;
  logic pulse_reg;

  wire pre_wrap = mclk_tick && (pre_reg == `AFRMC_PRE_MAX);
  wire fs_wrap = pre_wrap && (fs_cnt_reg == fs_code - 10'h001);
  wire mult_wrap = fs_wrap && (mult_cnt_reg == mult - 3'h1);

  // master clock / 1024 / code / multiplier
  always_ff @(posedge core_clk) begin
    if (reset || restart) begin
      pre_reg <= 10'h000;
      fs_cnt_reg <= 10'h000;
      mult_cnt_reg <= 3'h0;
      pulse_reg <= 1'b0;
    end else begin
      pulse_reg <= mult_wrap;
      if (mclk_tick) begin
        pre_reg <= pre_reg + 10'h001;
      end
      if (pre_wrap) begin
        fs_cnt_reg <= fs_wrap ? 10'h000 : fs_cnt_reg + 10'h001;
      end
      if (fs_wrap) begin
        mult_cnt_reg <= mult_wrap ? 3'h0 : mult_cnt_reg + 3'h1;
      end
    end
  end

  assign conv_pulse = pulse_reg;

endmodule

// file: verilog/afrmc_top.sv
// filter rate and mode control: rate, settling, notches, data word
`timescale 1ns/1ns
`include "afrmc_defines.svh"

module afrmc_top (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // configuration
  input wire afrmc_pkg::afrmc_cfg_type cfg_in,
  input wire logic cfg_load,
  // master clock pin
  input wire logic mclk_pin,
  // modulator side
  input wire afrmc_pkg::afrmc_sample_type sample_in,
  // conversion results
  output logic conv_strobe_reg,
  output logic data_valid_reg,
  output logic [31:0] read_word_reg,
  output logic [5:0] read_bits_reg,
  // filter state
  output logic [22:0] divide_total_reg,
  output logic [2:0] filter_order_reg,
  output logic zero_latency_reg,
  output afrmc_pkg::afrmc_notch_type notch_reg,
  output logic cfg_error_reg
);

  // ----------------------------------------
  // configuration register
  // ----------------------------------------
  afrmc_pkg::afrmc_cfg_type cfg_reg;
  logic restart_reg;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cfg_reg <= '0;
      cfg_reg.continuous_mode <= 1'b1;
      cfg_reg.rate_divider_code <= `AFRMC_FS_RESET;
      restart_reg <= 1'b0;
    end else begin
      restart_reg <= cfg_load;
      if (cfg_load) begin
        cfg_reg <= cfg_in;
      end
    end
  end

  // ----------------------------------------
  // master clock synchroniser
  // ----------------------------------------
  logic mclk_s1_reg;
  logic mclk_s2_reg;
  logic mclk_s3_reg;
  logic mclk_lvl_reg;

  wire mclk_agree = (mclk_s2_reg == mclk_s3_reg);
  wire mclk_tick = mclk_agree && mclk_s3_reg && !mclk_lvl_reg;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      mclk_s1_reg <= 1'b0;
      mclk_s2_reg <= 1'b0;
      mclk_s3_reg <= 1'b0;
      mclk_lvl_reg <= 1'b0;
    end else begin
      mclk_s1_reg <= mclk_pin;
      mclk_s2_reg <= mclk_s1_reg;
      mclk_s3_reg <= mclk_s2_reg;
      if (mclk_agree) begin
        mclk_lvl_reg <= mclk_s3_reg;
      end
    end
  end

  // ----------------------------------------
  // rate decode
  // ----------------------------------------
  wire fs_zero = (cfg_reg.rate_divider_code == 10'h000);
  wire [9:0] fs_eff = fs_zero ? 10'h001 : cfg_reg.rate_divider_code;
  wire [2:0] order_n = cfg_reg.filter_order_select ? `AFRMC_ORDER_FILTER_ORDER_SELECT
                                                   : `AFRMC_ORDER_SINC4;
  wire zl_eff = cfg_reg.single_cycle_settle && !cfg_reg.multi_channel
                && cfg_reg.continuous_mode;
  wire [2:0] mult = (cfg_reg.chop_enable || zl_eff) ? order_n : 3'h1;
  wire [22:0] divide_total = 23'(`AFRMC_PRE_DIV) * 23'(fs_eff) * 23'(mult);
  wire [2:0] settle_need = (cfg_reg.chop_enable || zl_eff) ? 3'h0 : order_n - 3'h1;

  logic conv_pulse;

  afrmc_rate_div u_rate_div (
    .core_clk(core_clk),
    .reset(reset),
    .restart(restart_reg),
    .mclk_tick(mclk_tick),
    .fs_code(fs_eff),
    .mult(mult),
    .conv_pulse(conv_pulse)
  );

  // ----------------------------------------
  // notch decode
  // ----------------------------------------
  wire at_rate = !cfg_reg.chop_enable && !cfg_reg.multi_channel;
  wire is_50hz = at_rate && (fs_eff == 10'(`AFRMC_FS_50HZ));
  wire add_60 = cfg_reg.sixty_hertz_notch_enable && is_50hz;
  wire cfg_bad = cfg_reg.reserved_zero_bit || fs_zero;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      divide_total_reg <= 23'h000000;
      filter_order_reg <= `AFRMC_ORDER_SINC4;
      zero_latency_reg <= 1'b0;
      notch_reg <= '0;
      cfg_error_reg <= 1'b0;
    end else begin
      divide_total_reg <= divide_total;
      filter_order_reg <= order_n;
      zero_latency_reg <= zl_eff;
      notch_reg.first_notch_at_rate <= at_rate;
      notch_reg.first_notch_50hz <= is_50hz;
      notch_reg.notch_60hz_added <= add_60;
      notch_reg.chop_odd_notches <= cfg_reg.chop_enable;
      cfg_error_reg <= cfg_bad;
    end
  end

  // ----------------------------------------
  // settling and data word
  // ----------------------------------------
  logic [2:0] settle_reg;

  wire settled = (settle_reg == 3'h0);
  wire parity_bit = cfg_reg.parity_check_enable && (^sample_in.data);
  wire [7:0] status_byte = {!settled, cfg_bad, 1'b0, parity_bit, 1'b0, sample_in.chan};
  wire [31:0] word_app = {sample_in.data, status_byte};
  wire [31:0] word_plain = {8'h00, sample_in.data};
  wire [31:0] word_sel = cfg_reg.status_append_enable ? word_app : word_plain;
  wire [5:0] bits_sel = cfg_reg.status_append_enable ? `AFRMC_BITS_APPEND
                                                     : `AFRMC_BITS_PLAIN;

  always_ff @(posedge core_clk) begin
    if (reset || restart_reg) begin
      settle_reg <= reset ? 3'h3 : settle_need;
      conv_strobe_reg <= 1'b0;
      data_valid_reg <= 1'b0;
    end else begin
      conv_strobe_reg <= conv_pulse;
      if (conv_pulse) begin
        data_valid_reg <= settled;
        if (!settled) begin
          settle_reg <= settle_reg - 3'h1;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      read_word_reg <= 32'h00000000;
      read_bits_reg <= `AFRMC_BITS_PLAIN;
    end else if (conv_pulse && settled) begin
      read_word_reg <= word_sel;
      read_bits_reg <= bits_sel;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence load_s;
    cfg_load ##1 restart_reg;
  endsequence

  sequence zl_first_s;
    zl_eff && conv_pulse && !restart_reg;
  endsequence

  sequence discard_s;
    conv_pulse && !settled && !restart_reg;
  endsequence

  sequence kept_s;
    conv_pulse && settled && !restart_reg;
  endsequence

  parity_bit_value_a: assert property (@(posedge core_clk) disable iff (reset)
    (conv_pulse && settled && cfg_reg.status_append_enable)
    |=> read_word_reg[`AFRMC_ST_PAR] == $past(cfg_reg.parity_check_enable
        && (^sample_in.data)))
    else $error("parity bit does not match data");

  status_append_word_a: assert property (@(posedge core_clk) disable iff (reset)
    (conv_pulse && settled)
    |=> (read_bits_reg == ($past(cfg_reg.status_append_enable) ? 6'h20 : 6'h18))
        && (read_word_reg[31:8] == ($past(cfg_reg.status_append_enable)
            ? $past(sample_in.data) : {8'h00, $past(sample_in.data[23:8])})))
    else $error("data word layout wrong for append setting");

  zero_latency_first_a: assert property (@(posedge core_clk) disable iff (reset)
    zl_first_s |=> conv_strobe_reg && data_valid_reg)
    else $error("zero latency conversion not valid");

  zero_latency_settle_a: assert property (@(posedge core_clk) disable iff (reset)
    load_s ##1 (zl_eff && !cfg_load) |-> settled)
    else $error("zero latency output not settled at once");

  settle_ignored_a: assert property (@(posedge core_clk) disable iff (reset)
    (restart_reg && !cfg_reg.chop_enable
     && (cfg_reg.multi_channel || !cfg_reg.continuous_mode)) |=> !settled)
    else $error("single cycle settle active where it must be ignored");

  sixty_notch_a: assert property (@(posedge core_clk) disable iff (reset)
    ##1 notch_reg.notch_60hz_added == $past(cfg_reg.sixty_hertz_notch_enable
        && !cfg_reg.chop_enable && !cfg_reg.multi_channel
        && cfg_reg.rate_divider_code == 10'h060))
    else $error("60 Hz notch decode wrong");

  plain_rate_a: assert property (@(posedge core_clk) disable iff (reset)
    (!reset && !cfg_reg.chop_enable && !zl_eff && !fs_zero && !cfg_load)
    |=> divide_total_reg == 23'(1024) * 23'($past(cfg_reg.rate_divider_code)))
    else $error("plain output rate divide wrong");

  chop_rate_a: assert property (@(posedge core_clk) disable iff (reset)
    (cfg_reg.chop_enable && !fs_zero)
    |=> divide_total_reg == 23'(1024) * 23'($past(cfg_reg.rate_divider_code))
        * ($past(cfg_reg.filter_order_select) ? 23'(3) : 23'(4)))
    else $error("chop conversion rate divide wrong");

  notch_at_rate_a: assert property (@(posedge core_clk) disable iff (reset)
    !reset |=> notch_reg.first_notch_at_rate
        == $past(!cfg_reg.chop_enable && !cfg_reg.multi_channel))
    else $error("first notch placement flag wrong");

  chop_notches_a: assert property (@(posedge core_clk) disable iff (reset)
    ##1 notch_reg.chop_odd_notches == $past(cfg_reg.chop_enable))
    else $error("chop notch flag wrong");

  order_select_a: assert property (@(posedge core_clk) disable iff (reset)
    ##1 filter_order_reg == ($past(cfg_reg.filter_order_select) ? 3'h3 : 3'h4))
    else $error("filter order decode wrong");

  code_range_a: assert property (@(posedge core_clk) disable iff (reset)
    !reset |=> cfg_error_reg == ($past(cfg_reg.rate_divider_code) == 10'h000
        || $past(cfg_reg.reserved_zero_bit)))
    else $error("rate code range handling wrong");

  // ----------------------------------------
  // conversion and settling checks
  // ----------------------------------------
  strobe_one_cycle_a: assert property (@(posedge core_clk) disable iff (reset)
    conv_strobe_reg |=> !conv_strobe_reg)
    else $error("conversion strobe longer than one cycle");

  restart_clears_a: assert property (@(posedge core_clk) disable iff (reset)
    restart_reg |=> !conv_strobe_reg && !data_valid_reg)
    else $error("reload did not clear conversion state");

  unsettled_discard_a: assert property (@(posedge core_clk) disable iff (reset)
    discard_s |=> !data_valid_reg && $stable(read_word_reg))
    else $error("unsettled conversion was not discarded");

  valid_word_a: assert property (@(posedge core_clk) disable iff (reset)
    kept_s |=> conv_strobe_reg && data_valid_reg)
    else $error("settled conversion not flagged valid");

  settle_reload_a: assert property (@(posedge core_clk) disable iff (reset)
    restart_reg |=> settle_reg == (($past(cfg_reg.chop_enable) || $past(zl_eff)) ? 3'h0
        : ($past(cfg_reg.filter_order_select) ? 3'h2 : 3'h3)))
    else $error("settle count reload wrong");

  chop_no_discard_a: assert property (@(posedge core_clk) disable iff (reset)
    (restart_reg && cfg_reg.chop_enable) |=> settled)
    else $error("chop conversion not settled at once");

  zero_latency_rate_a: assert property (@(posedge core_clk) disable iff (reset)
    (zl_eff && !cfg_reg.chop_enable && !fs_zero)
    |=> divide_total_reg == 23'(1024) * 23'($past(cfg_reg.rate_divider_code))
        * ($past(cfg_reg.filter_order_select) ? 23'(3) : 23'(4)))
    else $error("zero latency conversion rate wrong");

  zero_latency_flag_a: assert property (@(posedge core_clk) disable iff (reset)
    !reset |=> zero_latency_reg == ($past(cfg_reg.single_cycle_settle)
        && !$past(cfg_reg.multi_channel) && $past(cfg_reg.continuous_mode)))
    else $error("zero latency flag wrong");

  fifty_notch_a: assert property (@(posedge core_clk) disable iff (reset)
    !reset |=> notch_reg.first_notch_50hz == (!$past(cfg_reg.chop_enable)
        && !$past(cfg_reg.multi_channel) && $past(cfg_reg.rate_divider_code) == 10'h060))
    else $error("50 Hz notch decode wrong");

  status_ready_a: assert property (@(posedge core_clk) disable iff (reset)
    (conv_pulse && settled && cfg_reg.status_append_enable)
    |=> !read_word_reg[`AFRMC_ST_RDY_N])
    else $error("status byte shows an unsettled conversion");

  status_error_a: assert property (@(posedge core_clk) disable iff (reset)
    (conv_pulse && settled && cfg_reg.status_append_enable)
    |=> read_word_reg[`AFRMC_ST_ERR] == ($past(cfg_reg.reserved_zero_bit)
        || $past(cfg_reg.rate_divider_code) == 10'h000))
    else $error("status byte config error bit wrong");

endmodule
